// >>> dv/quad_encoder_model.sv
// Incremental encoder model with index pulse and cable fault
`timescale 1ns/1ps
`default_nettype none
module quad_encoder_model (
    // Clock
    input  wire logic mclk,
    // Encoder lines
    output logic      chA,
    output logic      chANeg,
    output logic      chB,
    output logic      chBNeg,
    output logic      indexPulse
);
    logic [1:0] phase;
    logic       glitchA;
    logic       cut;
    initial begin
        phase = 2'h0;
        glitchA = 1'h0;
        cut = 1'h0;
        indexPulse = 1'h0;
    end
    // Phase counting up gives AB 00, 10, 11, 01
    always_comb begin
        chA = phase[0] ^ phase[1] ^ glitchA;
        chB = phase[1];
        // A broken cable leaves both lines of a pair at one level
        chANeg = cut ? chA : ~chA;
        chBNeg = cut ? chB : ~chB;
    end
    // Long enough for the pulse filter to accept a level
    task automatic settle();
        repeat (455) @(posedge mclk);
    endtask
    // Only one channel moves per step
    task automatic step(input logic up);
        @(posedge mclk);
        phase <= up ? phase + 2'h1 : phase - 2'h1;
        settle();
    endtask
    // Both channels move together, only on command
    task automatic dbl();
        @(posedge mclk);
        phase <= phase + 2'h2;
        settle();
    endtask
    // Pulse on A lasting n cycles, for probing the accept width
    task automatic glitch(input int n);
        @(posedge mclk);
        glitchA <= 1'h1;
        repeat (n) @(posedge mclk);
        glitchA <= 1'h0;
        settle();
    endtask
    task automatic index();
        @(posedge mclk);
        indexPulse <= 1'h1;
        repeat (10) @(posedge mclk);
        indexPulse <= 1'h0;
        repeat (5) @(posedge mclk);
    endtask
    task automatic cable(input logic broken);
        @(posedge mclk);
        cut <= broken;
        repeat (460) @(posedge mclk);
    endtask
endmodule
`default_nettype wire

// >>> dv/test_quadrature_position_counter.sv
// Self-checking bench for the quadrature position counter
`timescale 1ns/1ps
`default_nettype none
`include "qpc_map.svh"
module test_quadrature_position_counter;
    logic        mclk, resetn, psel, penable, pwrite, pready, pslverr;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, position;
    logic        chA, chANeg, chB, chBNeg, indexPulse, countReset, flagClear;
    logic        countingUp, countingDown, failure, indexSeen, irq;
    logic        countErrorFlag, rangeErrorFlag, cableDisconnect;
    logic [31:0] expQ[$];
    logic        errQ[$];
    logic [31:0] bias, user, held, fsExp;
    int          n_fail, comparisons, seed, r;

    // Short idle timeout keeps the run brief
    quadrature_position_counter #(.STILL_CYCLES(50)) u_quadrature_position_counter (
        .mclk, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .chA, .chANeg, .chB, .chBNeg, .indexPulse,
        .countReset, .flagClear, .countingUp, .countingDown, .failure,
        .indexSeen, .countErrorFlag, .rangeErrorFlag, .cableDisconnect,
        .position, .irq);
    quad_encoder_model u_quad_encoder_model (
        .mclk, .chA, .chANeg, .chB, .chBNeg, .indexPulse);

    initial begin
        mclk = 1'h0;
        forever #2.5 mclk = ~mclk;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic give_verdict();
        $display("comparisons=%0d n_fail=%0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        input logic er);
        errQ.push_back(er);
        @(posedge mclk);
        psel <= 1'h1;
        penable <= 1'h0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'h1;
        @(posedge mclk);
        while (pready !== 1'h1)
            @(posedge mclk);
        psel <= 1'h0;
        penable <= 1'h0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'h1, a, d, 1'h0);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic er = 1'h0);
        expQ.push_back(e);
        xfer(1'h0, a, 32'h0, er);
    endtask
    task automatic ctl(input logic rst, input logic clr);
        @(posedge mclk);
        countReset <= rst;
        flagClear <= clr;
        tick(3);
        countReset <= 1'h0;
        flagClear <= 1'h0;
        tick(3);
    endtask
    // Completed transfers are matched against the oldest note
    always @(posedge mclk) begin
        if (psel && penable && pready) begin
            check(32'(pslverr), 32'(errQ.pop_front()));
            if (!pwrite)
                check(prdata, expQ.pop_front());
        end
    end
    initial begin
        tick(60000);
        n_fail++;
        give_verdict();
    end
    initial begin
        seed = 60735;
        {psel, penable} = '0;
        pwrite = 1'($random(seed));
        paddr = 8'($random(seed));
        pwdata = $random(seed);
        countReset = 1'h0;
        flagClear = 1'h0;
        resetn = 1'h0;
        tick(6);
        resetn <= 1'h1;
        rd(`ADDR_CTRL, `CTRL_RESET);
        rd(`ADDR_SCALE, 32'(`SCALE_RESET));
        rd(`ADDR_POSITION, 32'h0);
        rd(8'h40, 32'h0, 1'h1);
        user = $random(seed);
        bias = $random(seed) & 32'h3ff;
        wr(`ADDR_UPPER, 32'h0010_0000);
        wr(`ADDR_LOWER, 32'hfff0_0000);
        wr(`ADDR_USER, user);
        wr(`ADDR_BIAS, bias);
        r = 0;
        for (int i = 0; i < 4; i++) begin
            u_quad_encoder_model.step(1'h1);
            r++;
            check(32'(countingUp), 32'h1);
            check(32'(countingDown), 32'h0);
        end
        rd(`ADDR_RAW, 32'(r));
        rd(`ADDR_POSITION, 32'(r) + bias);
        tick(60);
        check(32'(countingUp), 32'h0);
        for (int i = 0; i < 2; i++) begin
            u_quad_encoder_model.step(1'h0);
            r--;
            check(32'(countingDown), 32'h1);
            check(32'(countingUp), 32'h0);
        end
        // A pulse of exactly the minimum width is still noise
        u_quad_encoder_model.glitch(400);
        u_quad_encoder_model.glitch(450);
        rd(`ADDR_RAW, 32'(r));
        wr(`ADDR_SCALE, 32'h2);
        tick(3);
        rd(`ADDR_POSITION, 32'(r / 2) + bias);
        wr(`ADDR_SCALE, 32'h1);
        wr(`ADDR_CTRL, 32'h2);
        tick(3);
        rd(`ADDR_POSITION, 32'(r));
        // One full channel cycle in each resolution
        for (int m = 0; m < 3; m++) begin
            wr(`ADDR_CTRL, 32'h4 | 32'(m));
            for (int i = 0; i < 4; i++)
                u_quad_encoder_model.step(1'h1);
            r += 1 << m;
            rd(`ADDR_RAW, 32'(r));
        end
        ctl(1'h1, 1'h0);
        r = 0;
        rd(`ADDR_POSITION, bias);
        held = bias;
        for (int f = 0; f < 4; f++) begin
            // Let the previous failure time out so hold sees a clean value
            tick(60);
            wr(`ADDR_CTRL, 32'h6 | 32'(f << 4));
            u_quad_encoder_model.dbl();
            check(32'(failure), 32'h1);
            fsExp = (f == 0) ? user : (f == 1) ? 32'h0010_0000 :
                    (f == 2) ? 32'hfff0_0000 : held;
            check(position, fsExp);
        end
        tick(60);
        wr(`ADDR_CTRL, 32'h6);
        wr(`ADDR_UPPER, 32'hffff_ffff);
        tick(3);
        check(32'(rangeErrorFlag), 32'h1);
        wr(`ADDR_UPPER, 32'h0010_0000);
        tick(3);
        check(32'(rangeErrorFlag), 32'h1);
        ctl(1'h0, 1'h1);
        check(32'(rangeErrorFlag), 32'h0);
        check(32'(countErrorFlag), 32'h0);
        wr(`ADDR_CTRL, 32'he);
        wr(`ADDR_IRQ_CLR, 32'h1f);
        u_quad_encoder_model.step(1'h1);
        u_quad_encoder_model.index();
        check(32'(indexSeen), 32'h1);
        rd(`ADDR_RAW, 32'h0);
        rd(`ADDR_IRQ_STAT, 32'h4);
        check(32'(irq), 32'h0);
        wr(`ADDR_IRQ_EN, 32'h4);
        tick(2);
        check(32'(irq), 32'h1);
        wr(`ADDR_IRQ_CLR, 32'h4);
        tick(2);
        check(32'(irq), 32'h0);
        // Only the first index edge clears while enabled
        u_quad_encoder_model.step(1'h1);
        u_quad_encoder_model.index();
        rd(`ADDR_RAW, 32'h1);
        u_quad_encoder_model.cable(1'h1);
        check(32'(cableDisconnect), 32'h1);
        u_quad_encoder_model.cable(1'h0);
        check(32'(cableDisconnect), 32'h0);
        tick(3);
        give_verdict();
    end
endmodule
`default_nettype wire

// >>> hw/qpc_map.svh
// Register offsets, field positions, reset values and timing counts
`ifndef QPC_MAP_SVH
`define QPC_MAP_SVH
`define ADDR_CTRL       8'h00
`define ADDR_SCALE      8'h04
`define ADDR_BIAS       8'h08
`define ADDR_UPPER      8'h0c
`define ADDR_LOWER      8'h10
`define ADDR_USER       8'h14
`define ADDR_STATUS     8'h18
`define ADDR_POSITION   8'h1c
`define ADDR_RAW        8'h20
`define ADDR_IRQ_STAT   8'h24
`define ADDR_IRQ_EN     8'h28
`define ADDR_IRQ_CLR    8'h2c
`define CTRL_MODE_HI    1
`define CTRL_MODE_LO    0
`define CTRL_BIAS       2
`define CTRL_INDEX_CLEAR_ENABLE       3
`define CTRL_FS_HI      5
`define CTRL_FS_LO      4
`define CTRL_RESET      32'h0000_0006
`define SCALE_RESET     16'h0001
`define IRQ_W           5
`define IRQ_CNT         0
`define IRQ_RNG         1
`define IRQ_IDX         2
`define IRQ_CABLE       3
`define IRQ_FAIL        4
`define RAW_MAX         32'h7fff_ffff
`define RAW_MIN         32'h8000_0000
`define CLK_NS          5
`define MIN_PULSE_NS    2250
`define FILT_CYC        9'((`MIN_PULSE_NS + `CLK_NS - 1) / `CLK_NS)
`define STILL_NS        1000000
`define STILL_CYC       (`STILL_NS / `CLK_NS)
`endif

// >>> hw/qpc_pkg.sv
// Types shared by the quadrature position counter
`default_nettype none
package qpc_pkg;
    typedef enum logic [1:0] {
        RES_X1 = 2'b00,
        RES_X2 = 2'b01,
        RES_X4 = 2'b10
    } res_mode_t;
    typedef enum logic [1:0] {
        FS_USER  = 2'b00,
        FS_UPPER = 2'b01,
        FS_LOWER = 2'b10,
        FS_HOLD  = 2'b11
    } failsafe_t;
    typedef enum logic [1:0] {
        IDX_IDLE  = 2'b00,
        IDX_ARMED = 2'b01,
        IDX_DONE  = 2'b10
    } idx_state_t;
    typedef struct packed {
        res_mode_t  mode;
        logic       biasEn;
        logic       idxClrEn;
        failsafe_t  fsSel;
        logic [15:0] cpu;
        logic [31:0] bias;
        logic [31:0] upper;
        logic [31:0] lower;
        logic [31:0] user;
        logic [4:0] irqStat;
        logic [4:0] irqEn;
        logic [31:0] prdata;
        logic       aLvl;
        logic       bLvl;
        logic [8:0] aCnt;
        logic [8:0] bCnt;
        logic [8:0] cabCnt;
        logic [31:0] raw;
        logic [17:0] still;
        logic       up;
        logic       down;
        logic       count_error_flag;
        logic       range_error_flag;
        logic       idxSeen;
        logic       cable;
        logic       rstPrev;
        logic       clfPrev;
        logic       idxPrev;
        idx_state_t idx;
        logic [31:0] pos;
    } qpc_state_t;
endpackage
`default_nettype wire

// >>> hw/quadrature_position_counter.sv
// Quadrature decoder, position counter and APB register file
//
// The register offsets and the APB register port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "qpc_map.svh"

// Contract
// - Decode all four channel states for four times native resolution.
// - Channel A leading counts up; channel B leading counts down.
// - Counting-up indicator high only while count increases.
// - Counting-down indicator high only while count decreases.
// - Failure high whenever both direction indicators are high.
// - Channel pulses not longer than 2.25 us are rejected as noise.
// - Count-reset rising edge sets output to zero plus enabled bias.
// - Flag-clear rising edge clears count error and range error flags.
// - With index clear enabled, first index rising edge zeroes output; here it zeroes the count, so output is zero plus enabled bias.
// - Index-seen output rises when index detected while enabled.
// - Count error flag sets on count overflow or underflow.
// - Range error flag sets when scaled value leaves the range limits.
// - Cable-disconnect output rises when encoder cable is lost.
// - Bias added while enabled; bias enable defaults to on.
// - Output is count divided by counts per unit.
// - On failure output takes user, upper, lower or held value.
module quadrature_position_counter #(
    parameter int unsigned STILL_CYCLES = `STILL_CYC
) (
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        resetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // Encoder channels, true and complement
    input  wire logic        chA,
    input  wire logic        chANeg,
    input  wire logic        chB,
    input  wire logic        chBNeg,
    input  wire logic        indexPulse,
    // Edge-triggered controls
    input  wire logic        countReset,
    input  wire logic        flagClear,
    // Status
    output logic             countingUp,
    output logic             countingDown,
    output logic             failure,
    output logic             indexSeen,
    output logic             countErrorFlag,
    output logic             rangeErrorFlag,
    output logic             cableDisconnect,
    output logic [31:0]      position,
    output logic             irq
);

    qpc_pkg::qpc_state_t s_reg;
    qpc_pkg::qpc_state_t s_next;
    logic cntSet;
    logic rngSet;
    logic stepUpEv;
    logic stepDnEv;
    logic clearEv;
    logic dblStep;

    function automatic logic isMapped(input logic [7:0] a);
        case (a)
            `ADDR_CTRL, `ADDR_SCALE, `ADDR_BIAS, `ADDR_UPPER,
            `ADDR_LOWER, `ADDR_USER, `ADDR_STATUS, `ADDR_POSITION,
            `ADDR_RAW, `ADDR_IRQ_STAT, `ADDR_IRQ_EN, `ADDR_IRQ_CLR: return 1'b1;
            default: return 1'b0;
        endcase
    endfunction

    // A leads B walks 00,10,11,01; the opposite walk counts down
    function automatic logic stepIsUp(input logic pa, input logic pb,
                                      input logic na, input logic nb);
        if (pa != na) begin
            return na ^ pb;
        end
        return ~(nb ^ pa);
    endfunction

    function automatic logic stepCounts(input qpc_pkg::res_mode_t m,
                                        input logic aCh, input logic pb);
        case (m)
            qpc_pkg::RES_X1: return aCh & ~pb;
            qpc_pkg::RES_X2: return aCh;
            qpc_pkg::RES_X4: return 1'b1;
            default:         return 1'b1;
        endcase
    endfunction

    // Zero scale would stall the divider, so it is read as one
    function automatic logic [31:0] scaleCount(input logic [31:0] raw,
                                               input logic [15:0] cpu);
        logic signed [31:0] d;
        d = (cpu == 16'h0000) ? 32'sd1 : $signed({16'h0000, cpu});
        return 32'($signed(raw) / d);
    endfunction

    function automatic logic [8:0] filterStep(input logic pin, input logic lvl,
                                              input logic [8:0] cnt);
        if (pin == lvl) begin
            return 9'h000;
        end
        return cnt + 9'h001;
    endfunction

    always_comb begin
        logic aCh;
        logic bCh;
        logic dirUp;
        logic rstEdge;
        logic clfEdge;
        logic idxEdge;
        logic [31:0] val;
        logic [`IRQ_W-1:0] irqSet;
        aCh = 1'b0;
        bCh = 1'b0;
        dirUp = 1'b0;
        rstEdge = countReset & ~s_reg.rstPrev;
        clfEdge = flagClear & ~s_reg.clfPrev;
        idxEdge = indexPulse & ~s_reg.idxPrev;
        val = 32'h0;
        irqSet = '0;
        cntSet = 1'b0;
        rngSet = 1'b0;
        stepUpEv = 1'b0;
        stepDnEv = 1'b0;
        clearEv = 1'b0;
        s_next = s_reg;
        s_next.rstPrev = countReset;
        s_next.clfPrev = flagClear;
        s_next.idxPrev = indexPulse;

        // APB writes land in the access phase only
        if (psel && penable && pwrite) begin
            case (paddr)
                `ADDR_CTRL: begin
                    s_next.mode = qpc_pkg::res_mode_t'(
                        pwdata[`CTRL_MODE_HI:`CTRL_MODE_LO]);
                    s_next.biasEn = pwdata[`CTRL_BIAS];
                    s_next.idxClrEn = pwdata[`CTRL_INDEX_CLEAR_ENABLE];
                    s_next.fsSel = qpc_pkg::failsafe_t'(
                        pwdata[`CTRL_FS_HI:`CTRL_FS_LO]);
                end
                `ADDR_SCALE: s_next.cpu = pwdata[15:0];
                `ADDR_BIAS:  s_next.bias = pwdata;
                `ADDR_UPPER: s_next.upper = pwdata;
                `ADDR_LOWER: s_next.lower = pwdata;
                `ADDR_USER:  s_next.user = pwdata;
                `ADDR_IRQ_EN: s_next.irqEn = pwdata[`IRQ_W-1:0];
                `ADDR_IRQ_CLR: s_next.irqStat = s_reg.irqStat & ~pwdata[`IRQ_W-1:0];
                default: ;
            endcase
        end

        // Reads are captured in the setup phase so prdata is a flop
        if (psel && !penable && !pwrite) begin
            case (paddr)
                `ADDR_CTRL: s_next.prdata = {26'h0, s_reg.fsSel, s_reg.idxClrEn,
                                             s_reg.biasEn, s_reg.mode};
                `ADDR_SCALE: s_next.prdata = {16'h0, s_reg.cpu};
                `ADDR_BIAS:  s_next.prdata = s_reg.bias;
                `ADDR_UPPER: s_next.prdata = s_reg.upper;
                `ADDR_LOWER: s_next.prdata = s_reg.lower;
                `ADDR_USER:  s_next.prdata = s_reg.user;
                `ADDR_STATUS: s_next.prdata = {25'h0, s_reg.cable, s_reg.range_error_flag,
                    s_reg.count_error_flag, s_reg.idxSeen, s_reg.up & s_reg.down,
                    s_reg.down, s_reg.up};
                `ADDR_POSITION: s_next.prdata = s_reg.pos;
                `ADDR_RAW:      s_next.prdata = s_reg.raw;
                `ADDR_IRQ_STAT: s_next.prdata = {27'h0, s_reg.irqStat};
                `ADDR_IRQ_EN:   s_next.prdata = {27'h0, s_reg.irqEn};
                default:        s_next.prdata = 32'h0;
            endcase
        end

        // Each channel must hold its new level past the minimum width
        s_next.aCnt = filterStep(chA, s_reg.aLvl, s_reg.aCnt);
        if (s_next.aCnt > `FILT_CYC) begin
            s_next.aLvl = chA;
            s_next.aCnt = 9'h000;
        end
        s_next.bCnt = filterStep(chB, s_reg.bLvl, s_reg.bCnt);
        if (s_next.bCnt > `FILT_CYC) begin
            s_next.bLvl = chB;
            s_next.bCnt = 9'h000;
        end
        aCh = s_next.aLvl ^ s_reg.aLvl;
        bCh = s_next.bLvl ^ s_reg.bLvl;

        // Complement line matching its true line means a loose wire
        if ((chA == chANeg) || (chB == chBNeg)) begin
            if (s_reg.cabCnt != `FILT_CYC) begin
                s_next.cabCnt = s_reg.cabCnt + 9'h001;
            end else begin
                s_next.cable = 1'b1;
            end
        end else begin
            s_next.cabCnt = 9'h000;
            s_next.cable = 1'b0;
        end

        if (s_reg.still != 18'(STILL_CYCLES)) begin
            s_next.still = s_reg.still + 18'h00001;
        end else begin
            s_next.up = 1'b0;
            s_next.down = 1'b0;
        end

        if (aCh && bCh) begin
            // Direction is unknowable, so both indicators flag the fault
            s_next.up = 1'b1;
            s_next.down = 1'b1;
            s_next.still = 18'h00000;
        end else if (aCh || bCh) begin
            dirUp = stepIsUp(s_reg.aLvl, s_reg.bLvl,
                             s_next.aLvl, s_next.bLvl);
            if (stepCounts(s_reg.mode, aCh, s_reg.bLvl)) begin
                s_next.still = 18'h00000;
                s_next.up = dirUp;
                s_next.down = ~dirUp;
                stepUpEv = dirUp;
                stepDnEv = ~dirUp;
                if (dirUp) begin
                    cntSet = (s_reg.raw == `RAW_MAX);
                    s_next.raw = s_reg.raw + 32'h1;
                end else begin
                    cntSet = (s_reg.raw == `RAW_MIN);
                    s_next.raw = s_reg.raw - 32'h1;
                end
            end
        end

        // Index clear acts once per enable, on the first edge
        case (s_reg.idx)
            qpc_pkg::IDX_IDLE: begin
                s_next.idxSeen = 1'b0;
                if (s_reg.idxClrEn) begin
                    s_next.idx = qpc_pkg::IDX_ARMED;
                end
            end
            qpc_pkg::IDX_ARMED: begin
                if (!s_reg.idxClrEn) begin
                    s_next.idx = qpc_pkg::IDX_IDLE;
                end else if (idxEdge) begin
                    clearEv = 1'b1;
                    s_next.idxSeen = 1'b1;
                    s_next.idx = qpc_pkg::IDX_DONE;
                end
            end
            qpc_pkg::IDX_DONE: begin
                if (!s_reg.idxClrEn) begin
                    s_next.idx = qpc_pkg::IDX_IDLE;
                    s_next.idxSeen = 1'b0;
                end
            end
            default: s_next.idx = qpc_pkg::IDX_IDLE;
        endcase

        if (rstEdge || clearEv) begin
            s_next.raw = 32'h0;
            cntSet = 1'b0;
        end

        val = scaleCount(s_reg.raw, s_reg.cpu);
        if (s_reg.biasEn) begin
            val = val + s_reg.bias;
        end
        rngSet = ($signed(val) > $signed(s_reg.upper)) ||
                 ($signed(val) < $signed(s_reg.lower));

        // Clear first so a same-cycle error still lands
        if (clfEdge) begin
            s_next.count_error_flag = 1'b0;
            s_next.range_error_flag = 1'b0;
        end
        if (cntSet) begin
            s_next.count_error_flag = 1'b1;
        end
        if (rngSet) begin
            s_next.range_error_flag = 1'b1;
        end

        if (s_reg.up && s_reg.down) begin
            case (s_reg.fsSel)
                qpc_pkg::FS_USER:  s_next.pos = s_reg.user;
                qpc_pkg::FS_UPPER: s_next.pos = s_reg.upper;
                qpc_pkg::FS_LOWER: s_next.pos = s_reg.lower;
                qpc_pkg::FS_HOLD:  s_next.pos = s_reg.pos;
                default:           s_next.pos = s_reg.pos;
            endcase
        end else begin
            s_next.pos = val;
        end

        irqSet[`IRQ_CNT] = s_next.count_error_flag & ~s_reg.count_error_flag;
        irqSet[`IRQ_RNG] = s_next.range_error_flag & ~s_reg.range_error_flag;
        irqSet[`IRQ_IDX] = s_next.idxSeen & ~s_reg.idxSeen;
        irqSet[`IRQ_CABLE] = s_next.cable & ~s_reg.cable;
        irqSet[`IRQ_FAIL] = (s_next.up & s_next.down) & ~(s_reg.up & s_reg.down);
        // Set beats a same-cycle clear so no event is lost
        s_next.irqStat = s_next.irqStat | irqSet;
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            s_reg <= '0;
            s_reg.mode <= qpc_pkg::res_mode_t'(
                2'(`CTRL_RESET >> `CTRL_MODE_LO));
            s_reg.biasEn <= 1'(`CTRL_RESET >> `CTRL_BIAS);
            s_reg.cpu <= `SCALE_RESET;
            s_reg.idx <= qpc_pkg::IDX_IDLE;
        end else begin
            s_reg <= s_next;
        end
    end

    // Zero wait states: every access completes in its first access cycle
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~isMapped(paddr);
    assign prdata = s_reg.prdata;
    assign countingUp = s_reg.up;
    assign countingDown = s_reg.down;
    assign failure = s_reg.up & s_reg.down;
    assign indexSeen = s_reg.idxSeen;
    assign countErrorFlag = s_reg.count_error_flag;
    assign rangeErrorFlag = s_reg.range_error_flag;
    assign cableDisconnect = s_reg.cable;
    assign position = s_reg.pos;
    assign irq = |(s_reg.irqStat & s_reg.irqEn);

    // Both channels accepted in one cycle must raise the failure indicators
    assign dblStep = (s_next.aLvl != s_reg.aLvl) && (s_next.bLvl != s_reg.bLvl);

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!resetn);

    a_fail_cause: assert property (dblStep |=> failure && countingUp && countingDown)
        else $error("double step did not raise failure");
    a_up_step: assert property (stepUpEv |=> countingUp && !countingDown)
        else $error("up step did not set counting up only");
    a_down_step: assert property (stepDnEv |=> countingDown && !countingUp)
        else $error("down step did not set counting down only");
    a_filter_width: assert property ($changed(s_reg.aLvl) |->
        $past(s_reg.aCnt) == `FILT_CYC)
        else $error("channel A level accepted before minimum width");
    a_reset_zero: assert property (countReset && !s_reg.rstPrev |=> s_reg.raw == 32'h0)
        else $error("count reset edge did not zero the count");
    a_flag_clear: assert property ((flagClear && !s_reg.clfPrev && !cntSet && !rngSet)
        |=> !countErrorFlag && !rangeErrorFlag)
        else $error("flag clear edge left an error flag set");
    a_index_first: assert property (s_reg.idx == qpc_pkg::IDX_ARMED &&
        s_reg.idxClrEn && indexPulse && !s_reg.idxPrev |=> s_reg.raw == 32'h0 && indexSeen)
        else $error("armed index edge did not clear count");
    a_overflow_flag: assert property (cntSet |=> countErrorFlag)
        else $error("overflow did not set count error");
    a_range_flag: assert property (rngSet |=> rangeErrorFlag)
        else $error("range excursion did not set range error");
    a_flag_sticky: assert property (countErrorFlag &&
        !(flagClear && !s_reg.clfPrev) |=> countErrorFlag)
        else $error("count error dropped without clear edge");
    a_failsafe_upper: assert property (failure && s_reg.fsSel == qpc_pkg::FS_UPPER |=>
        position == $past(s_reg.upper))
        else $error("failsafe upscale not applied");
    a_x1_bstep: assert property (s_reg.mode == qpc_pkg::RES_X1 &&
        $changed(s_reg.bLvl) && !$changed(s_reg.aLvl) && !$past(countReset) |->
        s_reg.raw == $past(s_reg.raw))
        else $error("channel B edge counted in single resolution");

    c_up_count: cover property (stepUpEv ##[1:600] stepUpEv);
    c_down_count: cover property (stepDnEv);
    c_index_clear: cover property ($rose(indexSeen));
    c_fail: cover property ($rose(failure));
    c_overflow: cover property (cntSet);

endmodule
`default_nettype wire
